// file: hw/logic_check_defs.svh
`ifndef LOGIC_CHECK_DEFS_SVH
`define LOGIC_CHECK_DEFS_SVH

// Register addresses on the serial link.
`define ADDR_READBACK_SEL   5'h13
`define ADDR_CHECK_RESULTS  5'h14

// One bit per address: set where the address decodes to a real register.
`define ADDR_VALID_MASK     32'h11ff_87ff
// One bit per address: set where the register can only be read.
`define ADDR_READ_ONLY_MASK 32'h11c0_0000

// Flag positions inside the results register.
`define BIT_RESET_SEEN      4'd13
`define BIT_WATCHDOG        4'd11
`define BIT_LATCH           4'd8
`define BIT_INVERSE         4'd6
`define BIT_CAL_CRC         4'd5
`define BIT_ACCESS          4'd4
`define BIT_EDGE_COUNT      4'd2
`define BIT_SLIP            4'd1
`define BIT_FRAME_CRC       4'd0

// Reset value and the positions that always read zero.
`define RESULTS_RESET       14'h2000
`define RESULTS_RSVD_MASK   14'h1688

// Frame lengths in falling edges of the link clock.
`define EDGES_SHORT         6'd24
`define EDGES_LONG          6'd32

// Frame check polynomial, x^8 + x^2 + x + 1.
`define FRAME_CRC_POLY      8'h07

`endif

// file: hw/logic_check_pkg.sv
`default_nettype none

package logic_check_pkg;

    // The 24 payload bits of one serial frame, first bit received on top.
    typedef struct packed {
        logic        slip;  // Must be the inverse of the next bit.
        logic        rd;    // High for a read, low for a write.
        logic        spare; // Carried but not decoded here.
        logic [4:0]  addr;  // Target register address.
        logic [15:0] data;  // Write data or readback argument.
    } spi_word_s;

    // Check enables taken from the configuration register.
    typedef struct packed {
        logic wdt_en;     // Watchdog check.
        logic latch_en;   // Code latch monitor.
        logic inv_en;     // Inverted code copy check.
        logic cal_crc_en; // Calibration memory check.
        logic slip_en;    // Frame slip bit check.
        logic crc_en;     // Frame check sequence.
    } check_en_s;

    // Detection events on the logic clock.
    typedef struct packed {
        logic        wdt_expired;  // One-cycle pulse when the watchdog runs out.
        logic [15:0] latch_in;     // Code presented to the output latches.
        logic [15:0] latch_out;    // Code held by the output latches.
        logic [15:0] dac_code;     // Code driven by the core logic.
        logic [15:0] dac_code_inv; // Inverted copy of that code.
        logic        refresh_busy; // Calibration memory refresh in progress.
        logic        refresh_done; // One-cycle pulse at the end of a refresh.
        logic        refresh_bad;  // Check result, valid with refresh_done.
    } check_evt_s;

endpackage : logic_check_pkg

`default_nettype wire

// file: hw/logic_check_results.sv
// How it works
// - Any reset sets the reset-seen flag.
// - Flags stick until written with one.
// - Disabled checks read back as zero.
// - Watchdog expiry sets watchdog fault flag.
// - Latch output differing from input sets flag.
// - Code differing from inverted copy sets flag.
// - Failed calibration memory check sets flag.
// - Reserved address access sets illegal-access flag.
// - Writes before or during refresh are illegal.
// - Readback select during refreshes after the first stays legal.
// - Writes to read-only registers are dropped, flagged.
// - Wrong falling edge count sets count flag.
// - Top bit not inverse of next flags slip.
// - Failed frame check sets frame check flag.
// - Reset sets the reset-seen flag; other flags and reserved bits reset to zero.
`include "logic_check_defs.svh"
`default_nettype none

module logic_check_results
    import logic_check_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       ce,
    input  wire logic       sclk,
    input  wire logic       sync_n,
    input  wire logic       sdi,
    input  wire check_en_s  check_en,
    input  wire check_evt_s evt,
    output logic [13:0]     results_q,
    output logic            frame_taken_q
);

    // The masks are held as named constants so that single bits can be
    // picked out by address; a bare literal cannot be indexed.
    localparam logic [31:0] valid_addr_mask = `ADDR_VALID_MASK;     // Decoded addresses.
    localparam logic [31:0] read_only_mask  = `ADDR_READ_ONLY_MASK; // Read-only addresses.
    localparam logic [13:0] rsvd_flag_mask  = `RESULTS_RSVD_MASK;   // Always-zero flags.

    ////////////////////////////////////////////////////////////////////////////
    // Link side, clocked by the link clock.

    logic        fresh_q; // High between frames; the next edge starts a frame.
    logic [31:0] shift_q; // Bits of the current frame, last bit in bit 0.
    logic [5:0]  edges_q; // Falling edges seen in the current frame.

    // The link clock stops between frames, so the frame start is marked by
    // the select pin itself: it presets this flop to a constant.
    always_ff @(negedge sclk or posedge sync_n) begin
        if (sync_n) begin
            fresh_q <= 1'b1;
        end else begin
            fresh_q <= 1'b0;
        end
    end

    // Shift and count on each falling edge; the count saturates at 63.
    // Both hold after the frame ends so the logic clock can read them.
    always_ff @(negedge sclk) begin
        if (!sync_n) begin
            if (fresh_q) begin
                shift_q <= {31'h0000_0000, sdi};
                edges_q <= 6'h01;
            end else begin
                shift_q <= {shift_q[30:0], sdi};
                if (edges_q != 6'h3f) begin
                    edges_q <= edges_q + 6'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame end seen on the logic clock.

    logic sel_s1_q; // First synchroniser stage, read only by the second.
    logic sel_s2_q; // Second synchroniser stage.
    logic sel_s3_q; // Delayed copy for the rising edge.

    // The select pin comes from another domain, so it passes two flops.
    always_ff @(posedge clk) begin
        if (srst) begin
            sel_s1_q <= 1'b1;
            sel_s2_q <= 1'b1;
            sel_s3_q <= 1'b1;
        end else if (ce) begin
            sel_s1_q <= sync_n;
            sel_s2_q <= sel_s1_q;
            sel_s3_q <= sel_s2_q;
        end
    end

    // Once the raised select is synchronised the link registers have stood
    // still for two cycles, so they are read as stable words.
    logic frame_end;
    assign frame_end = ce && sel_s2_q && !sel_s3_q;

    ////////////////////////////////////////////////////////////////////////////
    // Frame checks.

    // Frame check sequence over the 24 payload bits, first bit first.
    function automatic logic [7:0] frame_crc(input logic [23:0] word);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--) begin
            if (c[7] ^ word[i]) begin
                c = {c[6:0], 1'b0} ^ `FRAME_CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        return c;
    endfunction : frame_crc

    spi_word_s  word;       // Payload of the frame just ended.
    logic       long_frame; // Frame of 32 edges, carrying a check byte.
    logic       count_err;  // Edge count not allowed in this mode.
    logic       slip_err;   // Slip bit not the inverse of the next bit.
    logic       crc_err;    // Check byte disagrees with the payload.
    logic       frame_ok;   // Frame fit to be decoded.
    logic       addr_bad;   // Reserved or undecoded address.
    logic       early_wr;   // Write before first refresh, or during one unless to the readback select.
    logic       ro_wr;      // Write to a register that is only read.
    logic       access_err; // Any illegal access in a decodable frame.
    logic       wr_results; // Legal write to the results register.
    logic       refreshed_q; // A calibration memory refresh has completed.

    // The decode is only meaningful while frame_end is high; at other times
    // the link registers may be moving under it.
    always_comb begin
        long_frame = (edges_q == `EDGES_LONG);
        word       = long_frame ? spi_word_s'(shift_q[31:8]) : spi_word_s'(shift_q[23:0]);
        count_err  = check_en.crc_en ? !long_frame
                                     : !(long_frame || edges_q == `EDGES_SHORT);
        slip_err   = !count_err && (word.slip == word.rd);
        crc_err    = !count_err && check_en.crc_en
                     && (frame_crc(word) != shift_q[7:0]);
        frame_ok   = !count_err && !slip_err && !crc_err;
        addr_bad   = !valid_addr_mask[word.addr];
        // A readback select during a refresh is allowed, but not before
        // the first refresh has ever finished.
        early_wr   = !word.rd && (!refreshed_q || (evt.refresh_busy
                     && word.addr != `ADDR_READBACK_SEL));
        ro_wr      = !word.rd && read_only_mask[word.addr];
        access_err = frame_ok && (addr_bad || early_wr || ro_wr);
        // Illegal writes are discarded: no register takes their data.
        wr_results = frame_end && frame_ok && !access_err && !word.rd
                     && word.addr == `ADDR_CHECK_RESULTS;
    end

    // Track whether the calibration memory has been refreshed since reset.
    always_ff @(posedge clk) begin
        if (srst) begin
            refreshed_q <= 1'b0;
        end else if (ce && evt.refresh_done) begin
            refreshed_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flag register.

    logic [13:0] detect;   // Conditions present this cycle.
    logic [13:0] clear;    // Write-one positions of a legal write.
    logic [13:0] flags_d;  // Next value of the flags.
    logic [13:0] flags_q;  // Sticky flags.
    logic [13:0] show;     // Positions visible on readback.

    // Frame detections count only in the cycle in which a frame ends; the
    // core's mismatch checks are levels and count in every cycle.
    always_comb begin
        detect                  = 14'h0000;
        detect[`BIT_WATCHDOG]   = evt.wdt_expired;
        detect[`BIT_LATCH]      = evt.latch_out != evt.latch_in;
        detect[`BIT_INVERSE]    = evt.dac_code != ~evt.dac_code_inv;
        detect[`BIT_CAL_CRC]    = evt.refresh_done && evt.refresh_bad;
        detect[`BIT_ACCESS]     = frame_end && access_err;
        detect[`BIT_EDGE_COUNT] = frame_end && count_err;
        detect[`BIT_SLIP]       = frame_end && slip_err;
        detect[`BIT_FRAME_CRC]  = frame_end && crc_err;
        clear = wr_results ? word.data[13:0] : 14'h0000;
    end

    // Each flag sets on a detection, else keeps its value unless written with one, then it takes its
    // present detection; a detection always wins over that clear.
    for (genvar i = 0; i < 14; i++) begin : g_flag
        if (rsvd_flag_mask[i]) begin : g_rsvd
            assign flags_d[i] = 1'b0;
        end else begin : g_live
            assign flags_d[i] = detect[i] || (flags_q[i] && !clear[i]);
        end
    end

    // Reset loads the reset-seen flag and clears the rest.
    always_ff @(posedge clk) begin
        if (srst) begin
            flags_q <= `RESULTS_RESET;
        end else if (ce) begin
            flags_q <= flags_d;
        end
    end

    // Flags of disabled checks read as zero; the flags themselves, all but the frame check flag, keep going.
    always_comb begin
        show                   = ~`RESULTS_RSVD_MASK;
        show[`BIT_WATCHDOG]    = check_en.wdt_en;
        show[`BIT_LATCH]       = check_en.latch_en;
        show[`BIT_INVERSE]     = check_en.inv_en;
        show[`BIT_CAL_CRC]     = check_en.cal_crc_en;
        show[`BIT_SLIP]        = check_en.slip_en;
        show[`BIT_FRAME_CRC]   = check_en.crc_en;
    end

    // Readback and frame strobe; the readback updates in the same cycle as the flags.
    always_ff @(posedge clk) begin
        if (srst) begin
            results_q     <= `RESULTS_RESET;
            frame_taken_q <= 1'b0;
        end else if (ce) begin
            results_q     <= flags_d & show;
            frame_taken_q <= frame_end;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the logic above.

    reset_seen_a: assert property (@(posedge clk)
        srst |=> flags_q[`BIT_RESET_SEEN] && (flags_q & ~14'h2000) == 14'h0000)
        else $error("reset-seen flag not set after reset");

    sticky_hold_a: assert property (@(posedge clk) disable iff (srst)
        !wr_results |=> (flags_q & $past(flags_q)) == $past(flags_q))
        else $error("flag dropped without a write");

    watchdog_set_a: assert property (@(posedge clk) disable iff (srst)
        ce && evt.wdt_expired |=> flags_q[`BIT_WATCHDOG])
        else $error("watchdog fault not flagged");

    latch_set_a: assert property (@(posedge clk) disable iff (srst)
        ce && evt.latch_out != evt.latch_in
        |=> flags_q[`BIT_LATCH] && results_q[`BIT_LATCH] == $past(check_en.latch_en))
        else $error("latch mismatch not flagged");

    inverse_set_a: assert property (@(posedge clk) disable iff (srst)
        ce && evt.dac_code != ~evt.dac_code_inv |=> flags_q[`BIT_INVERSE])
        else $error("inverse code mismatch not flagged");

    count_set_a: assert property (@(posedge clk) disable iff (srst)
        frame_end && count_err |=> flags_q[`BIT_EDGE_COUNT] && !$past(wr_results))
        else $error("edge count error not flagged");

    slip_set_a: assert property (@(posedge clk) disable iff (srst)
        frame_end && !count_err && word.slip == word.rd |=> flags_q[`BIT_SLIP])
        else $error("slip bit error not flagged");

    access_set_a: assert property (@(posedge clk) disable iff (srst)
        frame_end && frame_ok && !word.rd && !refreshed_q |=> flags_q[`BIT_ACCESS])
        else $error("early write not flagged");

    // Before the first reset the flags are unknown, so this check waits for
    // the reset to be released like all the others but reset_seen_a.
    reserved_zero_a: assert property (@(posedge clk) disable iff (srst)
        (flags_q & `RESULTS_RSVD_MASK) == 14'h0000)
        else $error("reserved flag bit set");

    readback_mask_a: assert property (@(posedge clk) disable iff (srst)
        ce && !check_en.wdt_en |=> !results_q[`BIT_WATCHDOG])
        else $error("disabled watchdog flag visible");

    // The checks below cover the remaining flag sources and the clear path.
    // Each looks one cycle after its trigger, when the flag must have set, held or cleared.
    cal_crc_set_a: assert property (@(posedge clk) disable iff (srst)
        ce && evt.refresh_done && evt.refresh_bad |=> flags_q[`BIT_CAL_CRC])
        else $error("calibration memory check not flagged");

    frame_crc_set_a: assert property (@(posedge clk) disable iff (srst)
        frame_end && crc_err |=> flags_q[`BIT_FRAME_CRC])
        else $error("frame check error not flagged");

    reserved_addr_a: assert property (@(posedge clk) disable iff (srst)
        frame_end && frame_ok && addr_bad |=> flags_q[`BIT_ACCESS])
        else $error("reserved address access not flagged");

    read_only_a: assert property (@(posedge clk) disable iff (srst)
        frame_end && frame_ok && !word.rd && read_only_mask[word.addr]
        |=> flags_q[`BIT_ACCESS])
        else $error("write to read-only register not flagged");

    readback_legal_a: assert property (@(posedge clk) disable iff (srst)
        frame_end && frame_ok && !word.rd && refreshed_q && word.addr == `ADDR_READBACK_SEL
        |=> flags_q[`BIT_ACCESS] == $past(flags_q[`BIT_ACCESS]))
        else $error("readback select wrongly flagged");

    clear_taken_a: assert property (@(posedge clk) disable iff (srst)
        wr_results && detect == 14'h0000 |=> (flags_q & $past(clear)) == 14'h0000)
        else $error("written flag not cleared");

    write_dropped_a: assert property (@(posedge clk) disable iff (srst)
        frame_end && access_err |=> (flags_q & $past(flags_q)) == $past(flags_q))
        else $error("illegal write changed the flags");

endmodule : logic_check_results

`default_nettype wire

// file: testbench/spi_host_model.sv
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// Serial host on the far side of the flag block. The link clock idles high
// and stands still between frames; data changes while the clock is high.
module spi_host_model;
    timeunit 1ns;
    timeprecision 1ps;

    logic sclk;   // Link clock, 64 ns period inside frames only.
    logic sync_n; // Frame select, active low.
    logic sdi;    // Serial data, first bit of the word first.

    // Idle levels at time zero.
    initial begin
        sclk = 1'b1;
        sync_n = 1'b1;
        sdi = 1'b0;
    end

    // Shifts the top n bits of word; a count other than 24 or 32 breaks framing.
    task automatic send(input logic [31:0] word, input int n);
        #13;
        sync_n = 1'b0;
        for (int i = 31; i > 31 - n; i--) begin
            sdi = word[i];
            #32 sclk = 1'b0;
            #32 sclk = 1'b1;
        end
        #32 sync_n = 1'b1;
        // The released line shows the inverse, so a held value is never trusted.
        sdi = ~sdi;
    endtask : send
endmodule : spi_host_model

`default_nettype wire

// file: testbench/test_logic_check_results.sv
`include "logic_check_defs.svh"
`default_nettype none
`define CHK(got, exp) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        failures++; \
        $display("[ERR] %0t got %h expected %h", $time, got, exp); \
    end \
end

module test_logic_check_results
    import logic_check_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk;           // Logic clock, 8 ns.
    logic        srst;          // Synchronous reset.
    logic        ce;            // Clock enable, low for one short spell.
    check_en_s   check_en;      // Check enables.
    check_evt_s  evt;           // Detection inputs.
    logic [13:0] results_q;     // Flag readback.
    logic        frame_taken_q; // Frame end pulse.
    int          failures;      // Mismatches seen.
    int          tests_run;     // Comparisons made.
    int          cycles;        // Cycles since start, for the hang limit.
    logic [5:0]  rsvd_acc [4] = '{6'h2b, 6'h0e, 6'h39, 6'h1f}; // {rd, addr}.
    logic [4:0]  ro_addr [4] = '{5'h16, 5'h17, 5'h18, 5'h1c};  // Read-only targets.

    spi_host_model spi_host_model_i ();
    logic_check_results logic_check_results_i (.clk(clk), .srst(srst), .ce(ce),
        .sclk(spi_host_model_i.sclk), .sync_n(spi_host_model_i.sync_n),
        .sdi(spi_host_model_i.sdi), .check_en(check_en), .evt(evt),
        .results_q(results_q), .frame_taken_q(frame_taken_q));

    always #4 clk = ~clk;

    // A run of about 7k cycles is expected; far beyond that it has hung.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame check byte, poly 0x07, zero start, first bit first.
    function automatic logic [7:0] crc8(input logic [23:0] p);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--) begin
            c = (c[7] ^ p[i]) ? ({c[6:0], 1'b0} ^ `FRAME_CRC_POLY) : {c[6:0], 1'b0};
        end
        return c;
    endfunction : crc8

    // Sends one frame and waits for the block to take it; n of 0 picks the legal length.
    task automatic xfer(input logic rd, input logic [4:0] addr, input logic [15:0] data,
                        input int n, input logic bad_slip, input logic bad_crc);
        spi_word_s w;
        int        k;
        w = '{slip: ~rd ^ bad_slip, rd: rd, spare: 1'b0, addr: addr, data: data};
        k = (n != 0) ? n : (check_en.crc_en ? 32 : 24);
        spi_host_model_i.send({w, crc8(w) ^ {7'h00, bad_crc}}, k);
        k = 0;
        while (frame_taken_q !== 1'b1 && k < 50) begin
            @(negedge clk);
            k++;
        end
        if (k == 50) begin
            failures++;
            $display("[ERR] %0t frame end never reported", $time);
        end
        // Leaves the select high long enough before the next frame.
        repeat (4) @(negedge clk);
    endtask : xfer

    // Writes ones everywhere in the results register, then expects all clear.
    task automatic clr();
        xfer(1'b0, `ADDR_CHECK_RESULTS, 16'h3fff, 0, 1'b0, 1'b0);
        `CHK(results_q, 14'h0000)
    endtask : clr

    // One-cycle pulse of every event but the latch mismatch, then time for the readback to settle.
    task automatic settle();
        @(negedge clk);
        evt = '{default: '0, latch_out: evt.latch_out, dac_code_inv: 16'hffff};
        repeat (2) @(negedge clk);
    endtask : settle

    task automatic give_verdict();
        if (failures == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        srst = 1'b1;
        ce = 1'b1;
        check_en = 6'b111110;
        evt = '{default: '0, dac_code_inv: 16'hffff};
        failures = 0;
        tests_run = 0;
        cycles = 0;
        repeat (3) @(negedge clk);
        srst = 1'b0;
        `CHK(results_q, `RESULTS_RESET)
        repeat (3) @(negedge clk);
        // A write before the first refresh is dropped and flagged.
        xfer(1'b0, `ADDR_CHECK_RESULTS, 16'h2000, 0, 1'b0, 1'b0);
        `CHK(results_q, 14'h2010)
        evt.refresh_done = 1'b1;
        evt.refresh_bad = 1'b1;
        settle();
        `CHK(results_q, 14'h2030)
        clr();
        // During a refresh only the readback select may be written.
        evt.refresh_busy = 1'b1;
        xfer(1'b0, `ADDR_READBACK_SEL, 16'h0014, 0, 1'b0, 1'b0);
        `CHK(results_q, 14'h0000)
        xfer(1'b0, 5'h01, 16'h0001, 0, 1'b0, 1'b0);
        `CHK(results_q, 14'h0010)
        evt.refresh_busy = 1'b0;
        clr();
        foreach (rsvd_acc[i]) begin
            xfer(rsvd_acc[i][5], rsvd_acc[i][4:0], 16'h0000, 0, 1'b0, 1'b0);
            `CHK(results_q, 14'h0010)
            clr();
        end
        foreach (ro_addr[i]) begin
            xfer(1'b0, ro_addr[i], 16'hffff, 0, 1'b0, 1'b0);
            `CHK(results_q, 14'h0010)
            clr();
        end
        // A read of a decoded address is legal and leaves the flags alone.
        xfer(1'b1, `ADDR_CHECK_RESULTS, 16'h0000, 0, 1'b0, 1'b0);
        `CHK(results_q, 14'h0000)
        // Detections from the core, then masking by the enables.
        evt.wdt_expired = 1'b1;
        settle();
        `CHK(results_q, 14'h0800)
        evt.dac_code_inv = 16'hfffe;
        settle();
        `CHK(results_q, 14'h0840)
        evt.latch_out = 16'h0001;
        settle();
        `CHK(results_q, 14'h0940)
        check_en = 6'b000000;
        repeat (2) @(negedge clk);
        `CHK(results_q, 14'h0000)
        check_en = 6'b111110;
        repeat (2) @(negedge clk);
        `CHK(results_q, 14'h0940)
        // A clear while the mismatch persists keeps that flag.
        xfer(1'b0, `ADDR_CHECK_RESULTS, 16'h3fff, 0, 1'b0, 1'b0);
        `CHK(results_q, 14'h0100)
        evt.latch_out = 16'h0000;
        repeat (2) @(negedge clk);
        clr();
        // A pulse while the clock enable is low is not taken.
        ce = 1'b0;
        evt.wdt_expired = 1'b1;
        settle();
        ce = 1'b1;
        `CHK(results_q, 14'h0000)
        // Framing faults on the link.
        xfer(1'b0, `ADDR_CHECK_RESULTS, 16'h0000, 0, 1'b1, 1'b0);
        `CHK(results_q, 14'h0002)
        clr();
        xfer(1'b0, `ADDR_CHECK_RESULTS, 16'h0000, 28, 1'b0, 1'b0);
        `CHK(results_q, 14'h0004)
        clr();
        xfer(1'b0, `ADDR_CHECK_RESULTS, 16'h0000, 32, 1'b0, 1'b0);
        `CHK(results_q, 14'h0000)
        check_en = 6'b111111;
        xfer(1'b0, `ADDR_CHECK_RESULTS, 16'h0000, 24, 1'b0, 1'b0);
        `CHK(results_q, 14'h0004)
        clr();
        xfer(1'b0, `ADDR_CHECK_RESULTS, 16'h0000, 0, 1'b0, 1'b1);
        `CHK(results_q, 14'h0001)
        clr();
        // A reset in mid-run raises the reset-seen flag alone.
        srst = 1'b1;
        @(negedge clk);
        srst = 1'b0;
        `CHK(results_q, `RESULTS_RESET)
        `CHK(results_q & 14'h1fff, 14'h0000)
        give_verdict();
    end
endmodule : test_logic_check_results

`default_nettype wire
